// File: rtl/porg_top.sv
// Output register path of an I/O cell: SDR, DDR and 4:1 gearbox
// Functional notes
// - SDR sends slot A positive data through one storage element to the pad.
// - SDR storage element is selectable as D flip-flop or transparent latch.
// - DDR captures positive and negative data into registers at capture.
// - DDR latches the negative registered value in the following cycle.
// - One mux on the capture clock alternates the two DDR paths.
// - Gearbox takes four streams: A and B, positive and negative phase.
// - Gearbox registers all four inputs, then latches the two B values.
// - Gearbox serialises staged data through a mux steered by edge clocks.
// - Edge clocks carry gearbox data from system timing into edge slots.
// - Top-edge cells offer SDR and DDR but no x2 output gearing.
// - Bottom-edge cells offer SDR only, no DDR.
`include "porg_cfg.svh"

module porg_top #(
  parameter int                  W     = `PORG_DATA_W,
  parameter int                  DEPTH = `PORG_FIFO_DEPTH,
  parameter porg_pkg::porg_edge_e EDGE = porg_pkg::PORG_EDGE_SIDE
) (
  // Clock, reset, enable and static configuration
  input  wire logic                 sys_clk,
  input  wire logic                 nrst,
  input  wire logic                 ce,
  input  wire porg_pkg::porg_mode_e mode,
  input  wire logic                 sdrLatch,
  input  wire logic                 latchGate,
  // Edge-phase clocks from the strobe write control; sampled, never used as clocks
  input  wire logic                 edge_phase_clk0,
  input  wire logic                 edge_phase_clk1,
  // Core stream: one word carries all four lanes
  input  wire logic                 inValid,
  output logic                      inReady,
  input  wire logic [W-1:0]         pos_phase_data_a,
  input  wire logic [W-1:0]         neg_phase_data_a,
  input  wire logic [W-1:0]         pos_phase_data_b,
  input  wire logic [W-1:0]         neg_phase_data_b,
  // Pad data and status
  output logic      [W-1:0]         padOut,
  output logic                      ddrHighPhase,
  output porg_pkg::porg_mode_e      modeEff,
  output logic                      underrun
);

  localparam int FW = 4 * W;

  // Refuse parameters the logic cannot serve, before any cycle runs
  if (W < 1) begin : g_bad_width
    $error("porg_top: W must be at least 1");
  end
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("porg_top: DEPTH must be a power of two, at least 2");
  end
  if (EDGE != porg_pkg::PORG_EDGE_SIDE && EDGE != porg_pkg::PORG_EDGE_TOP &&
      EDGE != porg_pkg::PORG_EDGE_BOTTOM) begin : g_bad_edge
    $error("porg_top: EDGE names no die edge");
  end

  // Edge restrictions fold the requested mode onto what the cell offers
  // Code 11 is unassigned and runs as single rate rather than freezing the pad
  function automatic porg_pkg::porg_mode_e fold_mode(input porg_pkg::porg_mode_e req);
    porg_pkg::porg_mode_e m;
    m = req;
    if (EDGE == porg_pkg::PORG_EDGE_BOTTOM) begin
      m = porg_pkg::PORG_MODE_SDR;
    end else if (EDGE == porg_pkg::PORG_EDGE_TOP && req == porg_pkg::PORG_MODE_GEAR) begin
      m = porg_pkg::PORG_MODE_DDR;
    end else if (req != porg_pkg::PORG_MODE_DDR && req != porg_pkg::PORG_MODE_GEAR) begin
      m = porg_pkg::PORG_MODE_SDR;
    end
    return m;
  endfunction : fold_mode

  porg_stream_if #(.W(FW)) inS ();
  porg_stream_if #(.W(FW)) outS ();

  porg_pkg::porg_mode_e effMode;
  logic [1:0]           selS;
  logic [W-1:0]         hPosA;
  logic [W-1:0]         hNegA;
  logic [W-1:0]         hPosB;
  logic [W-1:0]         hNegB;
  logic                 take;
  logic                 wrap;
  logic                 enterANeg;

  // Datapath state
  logic         phase_r;
  logic         phase_nxt;

  // DDR capture pair and the held negative value
  logic [W-1:0] capPos_r;
  logic [W-1:0] capPos_nxt;
  logic [W-1:0] capNeg_r;
  logic [W-1:0] capNeg_nxt;
  logic [W-1:0] negLatch_r;
  logic [W-1:0] negLatch_nxt;

  // Gearbox staging word and the two B latches
  logic [W-1:0] stPosA_r;
  logic [W-1:0] stPosA_nxt;
  logic [W-1:0] stNegA_r;
  logic [W-1:0] stNegA_nxt;
  logic [W-1:0] stPosB_r;
  logic [W-1:0] stPosB_nxt;
  logic [W-1:0] stNegB_r;
  logic [W-1:0] stNegB_nxt;
  logic [W-1:0] latPosB_r;
  logic [W-1:0] latPosB_nxt;
  logic [W-1:0] latNegB_r;
  logic [W-1:0] latNegB_nxt;

  // Delayed slot, pad register and underrun pulse
  logic [1:0]   selD_r;
  logic [1:0]   selD_nxt;
  logic [W-1:0] pad_r;
  logic [W-1:0] pad_nxt;
  logic         under_r;
  logic         under_nxt;

  // Requested mode folded once, shared by every process below
  assign effMode = fold_mode(mode);

  // Input words enter the FIFO; its ready pushes back on the core
  assign inS.valid = inValid;
  assign inS.data  = {pos_phase_data_a, neg_phase_data_a, pos_phase_data_b, neg_phase_data_b};
  assign inReady   = inS.ready;

  porg_fifo #(
    .W     (FW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .ce      (ce),
    .wr      (inS.consumer),
    .rd      (outS.producer)
  );

  // Edge-phase clocks arrive from outside this domain
  // Sampled as levels, so each slot must last at least one system cycle;
  // a faster walk would skip slots, the price of keeping one clock here
  porg_sync #(
    .W (2)
  ) u_edge_sync (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .ce      (ce),
    .din     ({edge_phase_clk1, edge_phase_clk0}),
    .dout    (selS)
  );

  // Head word split back into its four lanes
  assign {hPosA, hNegA, hPosB, hNegB} = outS.data;

  // Slot sequence events seen through the synchronised edge clocks
  // Both compare the synchroniser with its delayed copy, so each fires once per entry
  assign wrap      = (selS == porg_pkg::PORG_SLOT_APOS) && (selD_r == porg_pkg::PORG_SLOT_BNEG);
  assign enterANeg = (selS == porg_pkg::PORG_SLOT_ANEG) && (selD_r == porg_pkg::PORG_SLOT_APOS);

  // Demand on the FIFO head depends on mode; a stalled demand fills the FIFO
  // Double rate takes a word only in the low phase, the gearbox only at the wrap
  always_comb begin
    case (effMode)
      porg_pkg::PORG_MODE_SDR:  outS.ready = sdrLatch ? latchGate : 1'b1;
      porg_pkg::PORG_MODE_DDR:  outS.ready = !phase_r;
      porg_pkg::PORG_MODE_GEAR: outS.ready = wrap;
      default:                  outS.ready = 1'b0;
    endcase
  end

  // A word leaves the FIFO only on an enabled edge
  assign take = ce && outS.valid && outS.ready;

  // Single rate: one word per enabled cycle, or only while the latch gate is open.
  // Double rate: capture in the low phase, show positive then negative data, so
  // each word takes two cycles; an empty FIFO at capture pulses underrun instead.
  // Gearbox: the word is staged when the synchronised slot wraps back to slot A positive,
  // and the B values move to latches on entry to slot A negative, so a later
  // staging cannot overwrite them before they reach the pad.
  // The pad mux follows the delayed slot, one cycle behind the synchroniser.
  // Next-state logic for all three modes
  always_comb begin
    phase_nxt    = phase_r;
    capPos_nxt   = capPos_r;
    capNeg_nxt   = capNeg_r;
    negLatch_nxt = negLatch_r;
    stPosA_nxt   = stPosA_r;
    stNegA_nxt   = stNegA_r;
    stPosB_nxt   = stPosB_r;
    stNegB_nxt   = stNegB_r;
    latPosB_nxt  = latPosB_r;
    latNegB_nxt  = latNegB_r;
    selD_nxt     = selD_r;
    pad_nxt      = pad_r;
    under_nxt    = under_r; // Frozen with all other state while ce is low
    if (ce) begin
      under_nxt = 1'b0;
      selD_nxt = selS;
      case (effMode)
        porg_pkg::PORG_MODE_SDR: begin
          // Flop mode loads every word; latch mode follows only while gate is open
          if (take) begin
            pad_nxt = hPosA;
          end
          phase_nxt = 1'b0;
        end
        porg_pkg::PORG_MODE_DDR: begin
          if (!phase_r) begin
            // Low phase: show the held negative value, capture the next pair
            pad_nxt = negLatch_r;
            if (take) begin
              capPos_nxt = hPosA;
              capNeg_nxt = hNegA;
              phase_nxt  = 1'b1;
            end else begin
              under_nxt = 1'b1;
            end
          end else begin
            // High phase: show positive data, latch negative so capture cannot disturb it
            pad_nxt      = capPos_r;
            negLatch_nxt = capNeg_r;
            phase_nxt    = 1'b0;
          end
        end
        porg_pkg::PORG_MODE_GEAR: begin
          phase_nxt = 1'b0;
          // Stage the whole word at the wrap so all four values belong together
          if (wrap) begin
            if (take) begin
              stPosA_nxt = hPosA;
              stNegA_nxt = hNegA;
              stPosB_nxt = hPosB;
              stNegB_nxt = hNegB;
            end else begin
              under_nxt = 1'b1; // Empty FIFO repeats the staged word
            end
          end
          // B values leave the staging word once slot A negative is under way
          if (enterANeg) begin
            latPosB_nxt = stPosB_r;
            latNegB_nxt = stNegB_r;
          end
          // Mux follows the delayed slot so staging is always settled first
          case (selD_r)
            porg_pkg::PORG_SLOT_APOS: pad_nxt = stPosA_r;
            porg_pkg::PORG_SLOT_ANEG: pad_nxt = stNegA_r;
            porg_pkg::PORG_SLOT_BPOS: pad_nxt = latPosB_r;
            porg_pkg::PORG_SLOT_BNEG: pad_nxt = latNegB_r;
            default:                  pad_nxt = pad_r;
          endcase
        end
        default: begin
          pad_nxt = pad_r;
        end
      endcase
    end
  end

  // Register stage only
  // Reset values come from the configuration header, except underrun which resets to 0; FIFO words are not reset
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase_r    <= `PORG_PHASE_RST;
      capPos_r   <= {W{`PORG_DATA_RST}};
      capNeg_r   <= {W{`PORG_DATA_RST}};
      negLatch_r <= {W{`PORG_DATA_RST}};
      stPosA_r   <= {W{`PORG_DATA_RST}};
      stNegA_r   <= {W{`PORG_DATA_RST}};
      stPosB_r   <= {W{`PORG_DATA_RST}};
      stNegB_r   <= {W{`PORG_DATA_RST}};
      latPosB_r  <= {W{`PORG_DATA_RST}};
      latNegB_r  <= {W{`PORG_DATA_RST}};
      selD_r     <= `PORG_SLOT_RST;
      pad_r      <= {W{`PORG_PAD_RST}};
      under_r    <= 1'b0;
    end else begin
      phase_r    <= phase_nxt;
      capPos_r   <= capPos_nxt;
      capNeg_r   <= capNeg_nxt;
      negLatch_r <= negLatch_nxt;
      stPosA_r   <= stPosA_nxt;
      stNegA_r   <= stNegA_nxt;
      stPosB_r   <= stPosB_nxt;
      stNegB_r   <= stNegB_nxt;
      latPosB_r  <= latPosB_nxt;
      latNegB_r  <= latNegB_nxt;
      selD_r     <= selD_nxt;
      pad_r      <= pad_nxt;
      under_r    <= under_nxt;
    end
  end

  // Outputs; high phase flag means positive DDR data is shown next
  // Mode fold is combinational, so a mode change acts at the next edge
  assign padOut       = pad_r;
  assign ddrHighPhase = phase_r;
  assign modeEff      = effMode;
  assign underrun     = under_r;

endmodule : porg_top

// File: rtl/porg_cfg.svh
// Constants for the output register and gearbox path
`ifndef PORG_CFG_SVH
`define PORG_CFG_SVH

`define PORG_DATA_W      1
`define PORG_FIFO_DEPTH  16
`define PORG_SYNC_STAGES 2
`define PORG_PAD_RST     1'h0
`define PORG_DATA_RST    1'h0
`define PORG_PHASE_RST   1'h0
`define PORG_SLOT_RST    2'h0

`endif

// File: rtl/porg_pkg.sv
// Types shared by the output register and gearbox path
package porg_pkg;

  // Requested output mode
  typedef enum logic [1:0] {
    PORG_MODE_SDR  = 2'b00,
    PORG_MODE_DDR  = 2'b01,
    PORG_MODE_GEAR = 2'b10
  } porg_mode_e;

  // Which edge of the die the cell sits on
  typedef enum logic [1:0] {
    PORG_EDGE_SIDE   = 2'b00,
    PORG_EDGE_TOP    = 2'b01,
    PORG_EDGE_BOTTOM = 2'b10
  } porg_edge_e;

  // Gearbox slot, as {edge_phase_clk1, edge_phase_clk0} in gray order
  typedef enum logic [1:0] {
    PORG_SLOT_APOS = 2'b00,
    PORG_SLOT_ANEG = 2'b01,
    PORG_SLOT_BPOS = 2'b11,
    PORG_SLOT_BNEG = 2'b10
  } porg_slot_e;

endpackage : porg_pkg

// File: rtl/porg_stream_if.sv
// Valid/ready stream carrier between the block's own modules
interface porg_stream_if #(
  parameter int W = 4
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport producer (output valid, output data, input ready);
  modport consumer (input valid, input data, output ready);
endinterface : porg_stream_if

// File: rtl/porg_sync.sv
// Two-flop level synchroniser for inputs from outside the clock domain
`include "porg_cfg.svh"

module porg_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic         ce,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  // First stage feeds only the second stage
  always_comb begin
    meta_nxt = ce ? din : meta_r;
    sync_nxt = ce ? meta_r : sync_r;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign dout = sync_r;

endmodule : porg_sync

// File: rtl/porg_fifo.sv
// Stream FIFO with memory and registered head word
`include "porg_cfg.svh"

module porg_fifo #(
  parameter int W     = 4,
  parameter int DEPTH = `PORG_FIFO_DEPTH
) (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  porg_stream_if.consumer wr,
  porg_stream_if.producer rd
);

  localparam int AW = $clog2(DEPTH);

  // Elaboration check: pointers wrap freely only for a power-of-two depth
  if (W < 1 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_params
    $error("porg_fifo: W must be positive and DEPTH a power of two, at least 2");
  end

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wrPtr_r;
  logic [AW-1:0] wrPtr_nxt;
  logic [AW-1:0] rdPtr_r;
  logic [AW-1:0] rdPtr_nxt;
  logic [AW:0]   count_r;
  logic [AW:0]   count_nxt;
  logic [W-1:0]  head_r;
  logic [W-1:0]  head_nxt;
  logic          headValid_r;
  logic          headValid_nxt;
  logic          push;
  logic          fetch;

  // Full is honest: memory ready drops once every entry holds a word
  assign wr.ready = (count_r != DEPTH[AW:0]);
  assign rd.valid = headValid_r;
  assign rd.data  = head_r;
  assign push     = ce && wr.valid && wr.ready;
  assign fetch    = ce && (count_r != '0) && (!headValid_r || rd.ready);

  // Pointer, count and head register updates
  always_comb begin
    wrPtr_nxt     = push ? wrPtr_r + AW'(1) : wrPtr_r;
    rdPtr_nxt     = fetch ? rdPtr_r + AW'(1) : rdPtr_r;
    count_nxt     = count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, fetch};
    head_nxt      = fetch ? mem[rdPtr_r] : head_r;
    headValid_nxt = headValid_r;
    if (fetch) begin
      headValid_nxt = 1'b1;
    end else if (ce && rd.ready) begin
      headValid_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr_r     <= '0;
      rdPtr_r     <= '0;
      count_r     <= '0;
      head_r      <= '0;
      headValid_r <= 1'b0;
    end else begin
      wrPtr_r     <= wrPtr_nxt;
      rdPtr_r     <= rdPtr_nxt;
      count_r     <= count_nxt;
      head_r      <= head_nxt;
      headValid_r <= headValid_nxt;
    end
  end

  // Storage array has no reset, so it maps onto plain RAM
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[wrPtr_r] <= wr.data;
    end
  end

endmodule : porg_fifo

// File: tb/porg_checker.sv
// Port-level assertions for the output register and gearbox path
module porg_checker #(
  parameter int                   W    = 1,
  parameter porg_pkg::porg_edge_e EDGE = porg_pkg::PORG_EDGE_SIDE
) (
  input wire logic                 sys_clk,
  input wire logic                 nrst,
  input wire logic                 ce,
  input wire porg_pkg::porg_mode_e mode,
  input wire logic                 sdrLatch,
  input wire logic                 latchGate,
  input wire logic                 edge_phase_clk0,
  input wire logic                 edge_phase_clk1,
  input wire logic                 inValid,
  input wire logic                 inReady,
  input wire logic [W-1:0]         padOut,
  input wire logic                 ddrHighPhase,
  input wire porg_pkg::porg_mode_e modeEff,
  input wire logic                 underrun
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  logic       isSdr, isDdr, isGear;
  logic [1:0] slot;
  logic [4:0] taken_r, taken_nxt;

  // Short mode flags keep the properties readable
  assign isSdr = modeEff == porg_pkg::PORG_MODE_SDR;
  assign isDdr = modeEff == porg_pkg::PORG_MODE_DDR;
  assign isGear = modeEff == porg_pkg::PORG_MODE_GEAR;
  assign slot = {edge_phase_clk1, edge_phase_clk0};

  // Words accepted since reset, saturating so it never wraps back under the depth
  always_comb begin
    taken_nxt = taken_r;
    if (ce && inValid && inReady && taken_r != 5'h1f) taken_nxt = taken_r + 5'h01;
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) taken_r <= 5'h00;
    else taken_r <= taken_nxt;
  end

  // Mode the cell should really run, given the edge it sits on
  function automatic porg_pkg::porg_mode_e fold(input porg_pkg::porg_mode_e m);
    if (m == porg_pkg::PORG_MODE_GEAR && EDGE == porg_pkg::PORG_EDGE_TOP) begin
      return porg_pkg::PORG_MODE_DDR;
    end
    if (EDGE == porg_pkg::PORG_EDGE_BOTTOM || m == 2'b11) return porg_pkg::PORG_MODE_SDR;
    return m;
  endfunction : fold

  sequence s_gearRun;
    (ce && isGear)[*5];
  endsequence
  sequence s_ddrHigh;
    ce && isDdr && ddrHighPhase;
  endsequence

  a_mode_fold: assert property (modeEff == fold(mode))
    else $error("folded mode wrong");
  a_reset_vals: assert property (disable iff (1'b0) !nrst |-> padOut == '0 && !underrun
    && !ddrHighPhase && inReady) else $error("reset values wrong");
  a_ready_room: assert property (taken_r < 5'h10 |-> inReady)
    else $error("refused with room left");
  a_latch_hold: assert property (isSdr && sdrLatch && !latchGate |=> $stable(padOut))
    else $error("closed latch changed pad");
  a_sdr_quiet: assert property ($past(ce) && $past(isSdr) |-> !underrun)
    else $error("underrun in single rate");
  a_ddr_quiet: assert property (s_ddrHigh |=> !underrun)
    else $error("underrun outside capture");
  a_ddr_alternate: assert property (s_ddrHigh ##1 ce |-> !ddrHighPhase)
    else $error("phase did not alternate");
  a_ddr_capture: assert property ($rose(ddrHighPhase) |-> !underrun)
    else $error("capture flagged underrun");
  a_gear_hold: assert property (s_gearRun ##0 ($past(slot, 2) == $past(slot, 5)
    && $past(slot, 3) == $past(slot, 5) && $past(slot, 4) == $past(slot, 5)) |-> $stable(padOut))
    else $error("pad moved with slot held");
endmodule : porg_checker

bind porg_top porg_checker #(.W(W), .EDGE(EDGE)) porg_checker_i (.sys_clk(sys_clk),
  .nrst(nrst), .ce(ce), .mode(mode), .sdrLatch(sdrLatch), .latchGate(latchGate),
  .edge_phase_clk0(edge_phase_clk0), .edge_phase_clk1(edge_phase_clk1), .inValid(inValid),
  .inReady(inReady), .padOut(padOut), .ddrHighPhase(ddrHighPhase), .modeEff(modeEff),
  .underrun(underrun));

// File: tb/porg_src.sv
// Core-side source model: offers queued words and holds each until taken
module porg_src #(
  parameter int W = 4
) (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic       inReady,
  input  wire logic       slow,
  output logic            inValid,
  output logic [4*W-1:0]  word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4*W-1:0] pend [$];
  logic           held;

  // Bench hands words over in order
  task automatic send(input logic [4*W-1:0] w);
    pend.push_back(w);
  endtask : send

  // Change only after the edge; a refused word stays put, idle lanes keep toggling
  always @(posedge sys_clk) begin
    held = inValid && !(ce && inReady);
    if (inValid && ce && inReady) void'(pend.pop_front());
    #1;
    if (!nrst) pend.delete();
    if (pend.size() > 0 && (held || !slow || $urandom_range(1, 0) == 1)) begin
      inValid = 1'b1;
      word = pend[0];
    end else begin
      inValid = 1'b0;
      word = ~word;
    end
  end
endmodule : porg_src

// File: tb/porg_top_tb.sv
// Self-checking bench: single rate, double rate, gearbox, latch and edge restrictions
module porg_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int W = 4;
  logic                 sys_clk, nrst, ce, sdrLatch, latchGate, slow, wild, walk;
  logic                 edge_phase_clk0, edge_phase_clk1, inValid;
  logic [4*W-1:0]       word;
  logic [4*W-1:0]       lastW;
  porg_pkg::porg_mode_e mode;
  porg_pkg::porg_mode_e modeEff [3];
  logic                 inReady [3], ddrHighPhase [3], underrun [3];
  logic [W-1:0]         padOut [3];
  int                   numErrors, samplesChecked, cycles;

  // One cell per die edge: side, top, bottom
  for (genvar e = 0; e < 3; e++) begin : g_edge
    porg_top #(.W(W), .EDGE(porg_pkg::porg_edge_e'(e))) porg_top_i (.sys_clk(sys_clk),
      .nrst(nrst), .ce(ce), .mode(mode), .sdrLatch(sdrLatch), .latchGate(latchGate),
      .edge_phase_clk0(edge_phase_clk0), .edge_phase_clk1(edge_phase_clk1), .inValid(inValid),
      .inReady(inReady[e]), .pos_phase_data_a(word[4*W-1-:W]), .neg_phase_data_a(word[3*W-1-:W]),
      .pos_phase_data_b(word[2*W-1-:W]), .neg_phase_data_b(word[W-1:0]), .padOut(padOut[e]),
      .ddrHighPhase(ddrHighPhase[e]), .modeEff(modeEff[e]), .underrun(underrun[e]));
  end
  porg_src #(.W(W)) porg_src_i (.sys_clk(sys_clk), .nrst(nrst), .ce(ce), .inReady(inReady[0]),
    .slow(slow), .inValid(inValid), .word(word));

  // Clock, 100 ns period
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Enable, gate and edge-phase walk, changed just after each edge
  always @(posedge sys_clk) begin
    #1;
    ce <= wild ? 1'($urandom) : 1'b1;
    latchGate <= (wild || !sdrLatch) ? 1'($urandom) : 1'b1;
    if (walk) {edge_phase_clk1, edge_phase_clk0} <= {edge_phase_clk0, !edge_phase_clk1};
  end

  // Hang guard
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      numErrors++;
      finishTest();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      numErrors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic finishTest();
    if (numErrors == 0 && samplesChecked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finishTest

  // Three cycles of reset, then one quiet cycle before traffic
  task automatic doReset(input porg_pkg::porg_mode_e m);
    nrst = 1'b0;
    mode = m;
    repeat (3) @(posedge sys_clk);
    #1 nrst = 1'b1;
    @(posedge sys_clk);
    #1;
  endtask : doReset

  // Continuous stream; pad must show the modelled sequence one value per cycle
  task automatic runStream(input porg_pkg::porg_mode_e m, input int n);
    logic [4*W-1:0] w;
    logic [W-1:0]   exp [$];
    int             k;
    bit             full, under;
    doReset(m);
    walk = (m == porg_pkg::PORG_MODE_GEAR);
    for (int i = 0; i < n; i++) begin
      w = 16'($urandom);
      w[4*W-1] = (i == 0) ? 1'b1 : w[4*W-1]; // First value never matches the reset pad
      porg_src_i.send(w);
      exp.push_back(w[4*W-1-:W]);
      if (m != porg_pkg::PORG_MODE_SDR) exp.push_back(w[3*W-1-:W]);
      if (m == porg_pkg::PORG_MODE_GEAR) exp.push_back(w[2*W-1-:W]);
      if (m == porg_pkg::PORG_MODE_GEAR) exp.push_back(w[W-1:0]);
    end
    k = 0;
    while (padOut[0] !== exp[0] && k < 60) begin
      under |= (underrun[0] === 1'b1);
      @(posedge sys_clk);
      #1 k++;
    end
    foreach (exp[i]) begin
      check("padOut", padOut[0], exp[i]);
      full |= (inReady[0] === 1'b0);
      @(posedge sys_clk);
      #1;
    end
    if (m != porg_pkg::PORG_MODE_SDR) check("refused", full, 1);
    if (m == porg_pkg::PORG_MODE_DDR) check("underrun", under, 1);
    walk = 1'b0;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask : runStream

  initial begin
    void'($urandom(59292));
    {nrst, sdrLatch, slow, wild, walk, edge_phase_clk0, edge_phase_clk1} = '0;
    {ce, latchGate} = 2'h3;
    mode = porg_pkg::PORG_MODE_SDR;
    doReset(porg_pkg::PORG_MODE_SDR);
    // Folded mode for every request on every edge
    for (int m = 0; m < 4; m++) begin
      mode = porg_pkg::porg_mode_e'(m);
      #1;
      for (int e = 0; e < 3; e++) begin
        check("modeEff", modeEff[e], (m == 3 || e == 2) ? 0 : (e == 1 && m == 2) ? 1 : m);
      end
    end
    runStream(porg_pkg::PORG_MODE_SDR, 24);
    runStream(porg_pkg::PORG_MODE_DDR, 48);
    runStream(porg_pkg::PORG_MODE_GEAR, 24);
    // Latch mode with a slow source, random gate and enable, then a settled tail
    doReset(porg_pkg::PORG_MODE_SDR);
    sdrLatch = 1'b1;
    slow = 1'b1;
    wild = 1'b1;
    for (int i = 0; i < 16; i++) porg_src_i.send(16'($urandom));
    repeat (60) @(posedge sys_clk);
    #1 wild = 1'b0;
    slow = 1'b0;
    repeat (4) begin
      lastW = 16'($urandom);
      porg_src_i.send(lastW);
    end
    repeat (20) @(posedge sys_clk);
    #1 check("latchPad", padOut[0], lastW[4*W-1-:W]);
    finishTest();
  end
endmodule : porg_top_tb
